// ### src/pport_pkg.sv
// Package with register map, field positions, modes and timing for the parallel port core.
package pport_pkg;

    localparam logic [2:0] OFF_DATA    = 3'h0;
    localparam logic [2:0] OFF_STATUS  = 3'h1;
    localparam logic [2:0] OFF_CONTROL = 3'h2;
    localparam logic [2:0] OFF_EADDR   = 3'h3;
    localparam logic [2:0] OFF_EDATA0  = 3'h4;
    localparam logic [2:0] OFF_EDATA3  = 3'h7;

    localparam int ST_TIMEOUT  = 0;
    localparam int ST_FAULT    = 3;
    localparam int ST_ONLINE   = 4;
    localparam int ST_PAPER    = 5;
    localparam int ST_ACCEPT   = 6;
    localparam int ST_READY    = 7;

    localparam int CT_STROBE   = 0;
    localparam int CT_FEED     = 1;
    localparam int CT_INIT     = 2;
    localparam int CT_SELECT   = 3;
    localparam int CT_IRQ_EN   = 4;
    localparam int CT_DIR      = 5;

    localparam logic [7:0] DATA_RESET    = 8'h00;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [7:0] CONTROL_MASK  = 8'h3F;

    localparam int CLK_HZ         = 25000000;
    localparam int TIMEOUT_US     = 10;
    localparam int TIMEOUT_CYCLES = (TIMEOUT_US * CLK_HZ) / 1000000;

    typedef enum logic [1:0]
    {
        MODE_PRINTER,
        MODE_BIDIR,
        MODE_ENHANCED,
        MODE_EXTENDED
    } port_mode_e;

    typedef struct packed
    {
        logic fault_input_n;
        logic online;
        logic paper_out;
        logic char_accept_n;
        logic busy;
    } cable_status_s;

    // Idle cable levels: accept high, every other status line low.
    localparam cable_status_s STATUS_IDLE = 5'h02;

    typedef struct packed
    {
        logic data_strobe_out_n;
        logic line_feed_out_n;
        logic peripheral_init_n;
        logic peripheral_select_out_n;
    } cable_control_s;

endpackage : pport_pkg

// ### src/printer_port_register_core.sv
// Register, APB slave and cable pin logic of the printer-style parallel port.
//
// How it works
// [RL1] Eight byte registers: data, status, control, address, four enhanced data ports.
// [RL2] Enhanced address and data ports answer only in enhanced mode.
// [RL3] Data latch clears on reset, takes host writes, drives cable lines uninverted.
// [RL4] Printer mode data read returns live cable line levels.
// [RL5] Status value is held steady through the whole read transfer.
// [RL6] Status bit 0 flags a ten microsecond enhanced bus timeout.
// [RL7] Timeout flag clears after status read, or on write of one, by selection.
// [RL8] Reset always clears the timeout flag.
// [RL9] Status bits 1 and 2 always read zero.
// [RL10] Status bits 3 to 6 show fault, online, paper and accept inputs uninverted.
// [RL11] Status bit 7 shows busy input inverted.
// [RL12] Reset clears control bits 0 to 5; bits 6 and 7 stay zero.
// [RL13] Control bits 0 and 1 drive strobe and line feed outputs inverted.
// [RL14] Control bit 2 drives the init output directly.
// [RL15] Control bit 3 drives the select output inverted.
// [RL16] Interrupt enable lets a rising accept edge raise the interrupt request.
// [RL17] Control bit 5 sets direction except in printer mode, always output.
// [RL18] Status register is writable only in enhanced mode.
// [RL19] Peripheral pulls accept low after taking a character.
// [RL20] Peripheral holds busy high while unable to accept a character.
// [RL21] Enhanced watchdog expiry aborts the cycle and sets the timeout flag.
// [RL22] Timeout-clear selection and port mode come in as configuration inputs.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns

module printer_port_register_core
#(
    parameter int TIMEOUT_CYCLES = pport_pkg::TIMEOUT_CYCLES
)
(
    // Clock and reset.
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // APB slave.
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    // Configuration.
    input  wire pport_pkg::port_mode_e     port_mode,
    input  wire logic                      timeout_clear_select,
    // Enhanced cycle watchdog.
    input  wire logic                      enhanced_cycle_active,
    output logic                           enhanced_cycle_abort,
    // Cable data lines, three-signal form, enable low while driving.
    input  wire logic [7:0]                cable_data_lines_in,
    output logic      [7:0]                cable_data_lines_out,
    output logic                           cable_data_lines_oe_n,
    // Cable status and control lines.
    input  wire pport_pkg::cable_status_s  cable_status,
    output pport_pkg::cable_control_s      cable_control,
    // Interrupt request.
    output logic                           port_irq
);

    logic [7:0]                parallel_data_latch;
    logic [5:0]                cable_line_control;
    logic                      bus_timeout_flag;
    logic [7:0]                status_hold;
    logic                      status_held;
    logic [7:0]                enhanced_ports [5];
    pport_pkg::cable_status_s  status_meta;
    pport_pkg::cable_status_s  status_sync;
    logic [7:0]                data_meta;
    logic [7:0]                data_sync;
    logic                      accept_prev;
    logic [$clog2(TIMEOUT_CYCLES + 1)-1:0] watchdog;
    logic [7:0]                next_status;
    logic [7:0]                next_rdata;
    logic                      next_slverr;
    logic [2:0]                reg_off;
    logic                      enhanced_mode;
    logic                      access;
    logic                      wr;
    logic                      rd;
    logic                      mapped;
    logic                      timeout_hit;
    logic                      drive_out;

    assign reg_off       = paddr[4:2];
    assign enhanced_mode = (port_mode == pport_pkg::MODE_ENHANCED);
    assign access        = psel && penable;
    assign wr            = access && pwrite && mapped;
    assign rd            = access && !pwrite && mapped;
    assign mapped        = (paddr[31:5] == 27'h0) && (paddr[1:0] == 2'h0)
                           && (reg_off < pport_pkg::OFF_EADDR || enhanced_mode); // [RL1] [RL2]
    assign timeout_hit   = enhanced_mode && enhanced_cycle_active
                           && (watchdog == ($bits(watchdog))'(TIMEOUT_CYCLES));

    // Cable inputs come from another domain, so two flops before use.
    // Reset loads the idle cable levels, so no false accept edge follows release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_meta <= pport_pkg::STATUS_IDLE;
            status_sync <= pport_pkg::STATUS_IDLE;
        end
        else
        begin
            status_meta <= cable_status;
            status_sync <= status_meta;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            data_meta <= 8'h00;
            data_sync <= 8'h00;
        end
        else
        begin
            data_meta <= cable_data_lines_in;
            data_sync <= data_meta;
        end
    end

    always_comb
    begin
        next_status = 8'h00; // [RL9]
        next_status[pport_pkg::ST_TIMEOUT] = bus_timeout_flag; // [RL6]
        next_status[pport_pkg::ST_FAULT]   = status_sync.fault_input_n; // [RL10]
        next_status[pport_pkg::ST_ONLINE]  = status_sync.online; // [RL10]
        next_status[pport_pkg::ST_PAPER]   = status_sync.paper_out; // [RL10]
        next_status[pport_pkg::ST_ACCEPT]  = status_sync.char_accept_n; // [RL10]
        next_status[pport_pkg::ST_READY]   = !status_sync.busy; // [RL11] [RL20]
    end

    // Snapshot taken at setup so the value cannot shift under the host mid-read.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            status_hold <= 8'h00;
            status_held <= 1'b0;
        end
        else if (psel && !penable)
        begin
            status_hold <= next_status; // [RL5]
            status_held <= 1'b1;
        end
        // Dropping the snapshot at the access edge keeps back-to-back reads fresh.
        else if (!psel || penable)
        begin
            status_held <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            parallel_data_latch <= pport_pkg::DATA_RESET; // [RL3]
        end
        else if (wr && reg_off == pport_pkg::OFF_DATA)
        begin
            parallel_data_latch <= pwdata[7:0]; // [RL3]
        end
        // Enhanced port writes also land here, so the byte reaches the cable lines.
        else if (wr && reg_off >= pport_pkg::OFF_EADDR)
        begin
            parallel_data_latch <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cable_line_control <= pport_pkg::CONTROL_RESET; // [RL12]
        end
        // Bits 6 and 7 have no storage, so they ignore writes and read as zero.
        else if (wr && reg_off == pport_pkg::OFF_CONTROL)
        begin
            cable_line_control <= pwdata[5:0]; // [RL12]
        end
    end

    genvar g;
    generate
        for (g = 0; g < 5; g++)
        begin : g_enh
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    enhanced_ports[g] <= 8'h00;
                end
                else if (wr && reg_off == pport_pkg::OFF_EADDR + 3'(g))
                begin
                    enhanced_ports[g] <= pwdata[7:0]; // [RL2]
                end
            end
        end
    endgenerate

    // Watchdog counts while an enhanced cycle is open; expiry aborts it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            watchdog <= '0;
        end
        else if (!enhanced_cycle_active || timeout_hit)
        begin
            watchdog <= '0;
        end
        else
        begin
            watchdog <= watchdog + 1'b1;
        end
    end

    // The abort is a one-cycle pulse; the sequencer outside ends its cycle on it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            enhanced_cycle_abort <= 1'b0;
        end
        else
        begin
            enhanced_cycle_abort <= timeout_hit; // [RL21]
        end
    end

    // Set wins over any clear landing in the same cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bus_timeout_flag <= 1'b0; // [RL8]
        end
        else if (timeout_hit)
        begin
            bus_timeout_flag <= 1'b1; // [RL6] [RL21]
        end
        else if (!timeout_clear_select && rd && reg_off == pport_pkg::OFF_STATUS)
        begin
            bus_timeout_flag <= 1'b0; // [RL7] [RL22]
        end
        else if (timeout_clear_select && enhanced_mode && wr
                 && reg_off == pport_pkg::OFF_STATUS && pwdata[pport_pkg::ST_TIMEOUT])
        begin
            bus_timeout_flag <= 1'b0; // [RL7] [RL18]
        end
    end

    always_comb
    begin
        next_rdata  = 8'h00;
        next_slverr = !mapped;
        unique case (reg_off)
            pport_pkg::OFF_DATA:
            begin
                next_rdata = (port_mode == pport_pkg::MODE_PRINTER) ? data_sync
                             : (drive_out ? parallel_data_latch : data_sync); // [RL4]
            end
            pport_pkg::OFF_STATUS:
            begin
                next_rdata = status_held ? status_hold : next_status; // [RL5]
            end
            pport_pkg::OFF_CONTROL:
            begin
                next_rdata = {2'h0, cable_line_control} & pport_pkg::CONTROL_MASK; // [RL12]
            end
            // Offsets 3 to 7 map onto the five enhanced entries, address port first.
            default:
            begin
                next_rdata = enhanced_ports[reg_off - pport_pkg::OFF_EADDR];
            end
        endcase
        if (!mapped)
        begin
            next_rdata = 8'h00;
        end
    end

    // Answer in the first access cycle: pready is high throughout, no wait states.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
        end
    end

    // The error is loaded at setup, so it stands for exactly the access cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr <= 1'b0;
        end
        else
        begin
            pslverr <= psel && !penable && next_slverr; // [RL2]
        end
    end

    // Read data is loaded at setup and stands until the next read setup.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= {24'h00_0000, next_rdata}; // [RL5]
        end
    end

    // Printer mode ignores the direction bit, so the lines never float there.
    assign drive_out = (port_mode == pport_pkg::MODE_PRINTER)
                       || !cable_line_control[pport_pkg::CT_DIR]; // [RL17]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cable_data_lines_out  <= 8'h00;
            cable_data_lines_oe_n <= 1'b0;
        end
        else
        begin
            cable_data_lines_out  <= parallel_data_latch; // [RL3]
            cable_data_lines_oe_n <= !drive_out; // [RL17]
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cable_control <= '{1'b1, 1'b1, 1'b0, 1'b1};
        end
        else
        begin
            cable_control.data_strobe_out_n <= !cable_line_control[pport_pkg::CT_STROBE]; // [RL13]
            cable_control.line_feed_out_n   <= !cable_line_control[pport_pkg::CT_FEED]; // [RL13]
            cable_control.peripheral_init_n <= cable_line_control[pport_pkg::CT_INIT]; // [RL14]
            cable_control.peripheral_select_out_n
                <= !cable_line_control[pport_pkg::CT_SELECT]; // [RL15]
        end
    end

    // Reset loads the idle accept level, so the edge detector sees no step at release.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            accept_prev <= 1'b1;
            port_irq    <= 1'b0;
        end
        else
        begin
            accept_prev <= status_sync.char_accept_n;
            port_irq    <= cable_line_control[pport_pkg::CT_IRQ_EN]
                           && status_sync.char_accept_n && !accept_prev; // [RL16] [RL19]
        end
    end

endmodule : printer_port_register_core

// ### bench/pport_props.sv
// Concurrent checks on the bus and pin behaviour of the parallel port core.
`timescale 1ns/1ns
module pport_props
#(
    parameter int TIMEOUT_CYCLES = 8
)
(
    // Bus side.
    input wire logic                      pclk,
    input wire logic                      presetn,
    input wire logic                      psel,
    input wire logic                      penable,
    input wire logic                      pwrite,
    input wire logic [31:0]               paddr,
    input wire logic [31:0]               pwdata,
    input wire logic [31:0]               prdata,
    input wire logic                      pslverr,
    // Pin side.
    input wire pport_pkg::port_mode_e     port_mode,
    input wire logic                      enhanced_cycle_active,
    input wire logic                      enhanced_cycle_abort,
    input wire logic [7:0]                cable_data_lines_out,
    input wire logic                      cable_data_lines_oe_n,
    input wire pport_pkg::cable_control_s cable_control,
    input wire logic                      port_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        acc;
    logic [15:0] run;
    assign acc = psel && penable;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run <= 16'h0000;
        else
            run <= enhanced_cycle_active ? run + 16'h0001 : 16'h0000;
    end
    // Pins are checked two edges on, which holds whether or not they carry an extra register.
    a_strobe_feed_pins: assert property (acc && pwrite && paddr == 32'h8 |-> ##2
        cable_control.data_strobe_out_n == !$past(pwdata[0], 2)
        && cable_control.line_feed_out_n == !$past(pwdata[1], 2))
        else $error("Strobe or feed pin does not follow the control write.");
    a_init_select_pins: assert property (acc && pwrite && paddr == 32'h8 |-> ##2
        cable_control.peripheral_init_n == $past(pwdata[2], 2)
        && cable_control.peripheral_select_out_n == !$past(pwdata[3], 2))
        else $error("Init or select pin does not follow the control write.");
    a_data_lines_drive: assert property (acc && pwrite && paddr == 32'h0 |-> ##2
        cable_data_lines_out == $past(pwdata[7:0], 2))
        else $error("Data lines do not follow the data write.");
    a_status_zero_bits: assert property (acc && !pwrite && paddr == 32'h4 |->
        prdata[2:1] == 2'b00 && prdata[31:8] == 24'h000000)
        else $error("Status read shows set bits in unused places.");
    a_control_top_zero: assert property (acc && !pwrite && paddr == 32'h8 |->
        prdata[31:6] == 26'h0)
        else $error("Control read shows set upper bits.");
    a_printer_dir_out: assert property (port_mode == pport_pkg::MODE_PRINTER
        && $past(port_mode) == pport_pkg::MODE_PRINTER |-> !cable_data_lines_oe_n)
        else $error("Data lines released in printer mode.");
    a_enhanced_refused: assert property (acc && paddr[4:2] >= 3'h3 && paddr[31:5] == 27'h0
        && paddr[1:0] == 2'b00 && port_mode != pport_pkg::MODE_ENHANCED
        |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("Enhanced port answered outside enhanced mode.");
    a_base_mapped: assert property (acc && paddr inside {32'h0, 32'h4, 32'h8} |-> !pslverr)
        else $error("Base register access refused.");
    a_irq_one_pulse: assert property (port_irq |=> !port_irq)
        else $error("Interrupt request longer than one cycle.");
    a_watchdog_span: assert property (enhanced_cycle_abort |->
        run >= TIMEOUT_CYCLES - 2 && run <= TIMEOUT_CYCLES + 2)
        else $error("Watchdog expired at the wrong count.");
    c_irq: cover property (port_irq);
    c_abort: cover property (enhanced_cycle_abort);
    c_refused: cover property (acc && pslverr);
    c_status_read: cover property (acc && !pwrite && paddr == 32'h4);
endmodule : pport_props

bind printer_port_register_core pport_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_props
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .port_mode,
    .enhanced_cycle_active, .enhanced_cycle_abort, .cable_data_lines_out,
    .cable_data_lines_oe_n, .cable_control, .port_irq
);

// ### bench/printer_model.sv
// Behavioural printer standing on the cable side of the port.
`timescale 1ns/1ns
module printer_model
(
    // Clock and bench controls.
    input  wire logic                      pclk,
    input  wire logic                      slow,
    input  wire logic [3:0]                lines,
    input  wire logic [7:0]                peer_byte,
    // Cable side.
    input  wire logic [7:0]                cable_data_lines_out,
    input  wire logic                      cable_data_lines_oe_n,
    input  wire pport_pkg::cable_control_s cable_control,
    output pport_pkg::cable_status_s       cable_status,
    output logic      [7:0]                cable_data_lines_in
);
    logic [4:0] left = 5'h00;
    logic       ack_n = 1'b1;
    // A strobe starts a busy spell; accept pulses low just after busy drops.
    always @(posedge pclk)
    begin
        if (left == 5'h00 && !cable_control.data_strobe_out_n)
            left <= slow ? 5'h14 : 5'h04;
        else if (left != 5'h00)
            left <= left - 5'h01;
        ack_n <= !(left == 5'h02);
    end
    assign cable_status = {lines[3:1], ack_n, lines[0] | (left > 5'h02)};
    // Once the host lets go, the peer byte stands on the lines instead of the stale one.
    assign cable_data_lines_in = cable_data_lines_oe_n ? peer_byte : cable_data_lines_out;
endmodule : printer_model

// ### bench/testbench.sv
// Self-checking testbench of the parallel port register core.
`timescale 1ns/1ns
module testbench;
    logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [31:0]               paddr, pwdata, prdata, w;
    pport_pkg::port_mode_e     port_mode;
    logic                      timeout_clear_select, enhanced_cycle_active, enhanced_cycle_abort;
    logic [7:0]                cable_data_lines_in, cable_data_lines_out, peer_byte;
    logic                      cable_data_lines_oe_n, port_irq, slow;
    logic [3:0]                lines;
    pport_pkg::cable_status_s  cable_status;
    pport_pkg::cable_control_s cable_control;
    logic [31:0]               expq[$];
    int                        mismatches, comparisons, irq_count, n;
    integer                    seed = 32'h8E0557F9;

    printer_port_register_core #(.TIMEOUT_CYCLES(8)) i_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .port_mode, .timeout_clear_select, .enhanced_cycle_active, .enhanced_cycle_abort,
        .cable_data_lines_in, .cable_data_lines_out, .cable_data_lines_oe_n, .cable_status,
        .cable_control, .port_irq
    );
    printer_model i_peer
    (
        .pclk, .slow, .lines, .peer_byte, .cable_data_lines_out, .cable_data_lines_oe_n,
        .cable_control, .cable_status, .cable_data_lines_in
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic close_out;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : close_out

    // Reads leave a note for the monitor; the idle edge keeps strobes single-driven per step.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       input logic [31:0] exp);
        int k;
        if (!wr)
            expq.push_back(exp);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        for (k = 0; k < 50 && pready !== 1'b1; k++)
            @(posedge pclk);
        check("pready", {31'h0, pready}, 32'h1);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    function automatic logic [31:0] st(input logic tmo);
        return {24'h0, ~cable_status.busy, cable_status.char_accept_n, cable_status.paper_out,
                cable_status.online, cable_status.fault_input_n, 2'b00, tmo};
    endfunction : st

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        if (port_irq === 1'b1)
            irq_count++;
        if (psel && penable && !pwrite && pready === 1'b1)
            check("read data", prdata, expq.pop_front());
    end

    initial
    begin
        #400000;
        mismatches++;
        close_out();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata, presetn, slow, lines, peer_byte} = '0;
        {timeout_clear_select, enhanced_cycle_active} = 2'b00;
        port_mode = pport_pkg::MODE_PRINTER;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, 32'h0, 32'h0, 32'h0);
        apb(1'b0, 32'h8, 32'h0, 32'h0);
        apb(1'b0, 32'h4, 32'h0, st(1'b0));
        check("control pins", {28'h0, cable_control}, 32'hD);
        $display("Test reset values done");
        for (int i = 0; i < 4; i++)
        begin
            w = (i == 0) ? 32'hFFFFFFFF : $random(seed);
            apb(1'b1, 32'h8, w, 32'h0);
            apb(1'b0, 32'h8, 32'h0, {26'h0, w[5:0]});
            check("control pins", {28'h0, cable_control}, {28'h0, ~w[0], ~w[1], w[2], ~w[3]});
        end
        $display("Test control done");
        apb(1'b1, 32'h8, 32'h0, 32'h0);
        repeat (8) @(posedge pclk);
        for (int i = 0; i < 4; i++)
        begin
            w = $random(seed);
            apb(1'b1, 32'h0, w, 32'h0);
            repeat (4) @(posedge pclk);
            check("data lines", {24'h0, cable_data_lines_out}, {24'h0, w[7:0]});
            apb(1'b0, 32'h0, 32'h0, {24'h0, w[7:0]});
        end
        $display("Test data done");
        for (int i = 0; i < 6; i++)
        begin
            lines <= 4'($random(seed));
            repeat (4) @(posedge pclk);
            apb(1'b0, 32'h4, 32'h0, st(1'b0));
        end
        $display("Test status lines done");
        for (int i = 0; i < 4; i++)
        begin
            slow <= i[0];
            n = irq_count;
            apb(1'b1, 32'h8, {27'h0, !i[1], 4'h1}, 32'h0);
            apb(1'b1, 32'h8, {27'h0, !i[1], 4'h0}, 32'h0);
            repeat (40) @(posedge pclk);
            check("irq count", irq_count - n, {31'h0, !i[1]});
        end
        $display("Test handshake done");
        port_mode <= pport_pkg::MODE_BIDIR;
        peer_byte <= 8'($random(seed));
        apb(1'b1, 32'h8, 32'h20, 32'h0);
        repeat (4) @(posedge pclk);
        check("line release", {31'h0, cable_data_lines_oe_n}, 32'h1);
        apb(1'b0, 32'h0, 32'h0, {24'h0, peer_byte});
        apb(1'b0, 32'hC, 32'h0, 32'h0);
        apb(1'b0, 32'h20, 32'h0, 32'h0);
        apb(1'b1, 32'h8, 32'h0, 32'h0);
        $display("Test direction done");
        port_mode <= pport_pkg::MODE_ENHANCED;
        for (int a = 3; a < 8; a++)
        begin
            w = $random(seed);
            apb(1'b1, 32'(a * 4), w, 32'h0);
            apb(1'b0, 32'(a * 4), 32'h0, {24'h0, w[7:0]});
        end
        for (int s = 0; s < 3; s++)
        begin
            timeout_clear_select <= (s != 0);
            enhanced_cycle_active <= 1'b1;
            for (n = 0; n < 100 && enhanced_cycle_abort !== 1'b1; n++)
                @(posedge pclk);
            enhanced_cycle_active <= 1'b0;
            check("abort", {31'h0, enhanced_cycle_abort}, 32'h1);
            repeat (2) @(posedge pclk);
            apb(1'b0, 32'h4, 32'h0, st(1'b1));
            apb(1'b0, 32'h4, 32'h0, st(s != 0));
            if (s == 1)
                apb(1'b1, 32'h4, 32'h1, 32'h0);
            if (s == 2)
            begin
                presetn <= 1'b0;
                repeat (2) @(posedge pclk);
                presetn <= 1'b1;
                repeat (4) @(posedge pclk);
            end
            if (s != 0)
                apb(1'b0, 32'h4, 32'h0, st(1'b0));
        end
        check("notes left", expq.size(), 32'h0);
        $display("Test enhanced done");
        close_out();
    end
endmodule : testbench
